// File: src/frame_watchdog.sv
// pseudo frame ticks and suspend after missed frames
`timescale 1ns/1ps
module frame_watchdog #(
  parameter int FRAME_LEN = 100000,
  parameter int MISS_LIMIT = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sof,
  output logic tick,
  output logic suspend
);
  localparam int CW = $clog2(FRAME_LEN);
  localparam int MW = $clog2(MISS_LIMIT + 1);
  initial begin
    if (FRAME_LEN < 2) $error("frame length too short");
    if (MISS_LIMIT < 1) $error("miss limit must be positive");
  end
  logic [CW-1:0] cnt_r, cnt_nxt; // cycles since last frame mark
  logic [MW-1:0] miss_r, miss_nxt; // consecutive missed frames
  logic tick_r, tick_nxt;
  // next-state: a real frame restarts everything
  always_comb begin
    cnt_nxt = cnt_r + 1'b1;
    miss_nxt = miss_r;
    tick_nxt = 1'b0;
    if (sof) begin
      cnt_nxt = '0;
      miss_nxt = '0;
    end else if (cnt_r == CW'(FRAME_LEN - 1)) begin
      // frame lost: stand in with a pseudo tick every period
      cnt_nxt = '0;
      tick_nxt = 1'b1;
      if (miss_r != MW'(MISS_LIMIT)) miss_nxt = miss_r + 1'b1;
    end
  end
  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      miss_r <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      miss_r <= miss_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick = tick_r;
  assign suspend = (miss_r == MW'(MISS_LIMIT));
endmodule // frame_watchdog

// File: src/irq_pulse_gen.sv
// fixed-width pulse on each rising edge of a level
`timescale 1ns/1ps
module irq_pulse_gen #(
  parameter int PULSE_LEN = 17
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic trig,
  output logic pulse
);
  localparam int CW = $clog2(PULSE_LEN + 1);
  initial begin
    if (PULSE_LEN < 1) $error("pulse length must be at least one cycle");
  end
  logic prev_r, prev_nxt; // last sampled trigger
  logic [CW-1:0] cnt_r, cnt_nxt; // cycles of pulse left
  logic pulse_r, pulse_nxt; // registered output
  // next-state: restart on a rise, otherwise count down
  always_comb begin
    prev_nxt = trig;
    cnt_nxt = cnt_r;
    if (trig && !prev_r) begin
      cnt_nxt = CW'(PULSE_LEN);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    pulse_nxt = (cnt_nxt != '0);
  end
  // register stage, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
      cnt_r <= '0;
      pulse_r <= 1'b0;
    end else if (ce) begin
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end
  assign pulse = pulse_r;
endmodule // irq_pulse_gen

// File: src/usb_irq_pkg.sv
// shared constants and carriers for the usb interrupt logic
package usb_irq_pkg;
  // register map, byte addresses on the 32-bit register bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_HWCFG = 8'h0c;
  localparam logic [7:0] OFS_EP_BASE = 8'h40;
  localparam int NUM_EP = 16;
  localparam int FLAG_W = 24;
  // status word bit positions
  localparam int BIT_BUS_RESET = 0;
  localparam int BIT_RESUME = 1;
  localparam int BIT_SUSP_CHG = 2;
  localparam int BIT_XFER_END = 3;
  localparam int BIT_SOF = 4;
  localparam int BIT_PSEUDO = 5;
  localparam int BIT_SPKT_END = 6;
  localparam int BIT_SLEEP = 7;
  localparam int BIT_EP_BASE = 8;
  // bus event flags cleared by a status read
  localparam logic [23:0] READ_CLR_MASK = 24'h00007f;
  // control bit positions and reset values
  localparam int MODE_GIE_BIT = 0;
  localparam int CFG_POL_BIT = 0;
  localparam int CFG_MODE_BIT = 1;
  localparam logic [23:0] ENABLE_RST = 24'h000000;
  localparam logic GIE_RST = 1'b0;
  localparam logic POL_RST = 1'b0;
  localparam logic SIGMODE_RST = 1'b0;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int PULSE_TIME_NS = 166;
  localparam int PULSE_CYCLES = (PULSE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int FRAME_TIME_NS = 1000000;
  localparam int FRAME_CYCLES = FRAME_TIME_NS / 1000 * CLK_FREQ_MHZ;
  localparam int MISSED_SOF_LIMIT = 3;
  // one-cycle bus events from the serial engine and dma, plus live bus level
  typedef struct packed {
    logic bus_reset;
    logic resume;
    logic short_packet_end;
    logic dma_count_zero;
    logic sof;
    logic bus_suspended;
  } bus_evt_t;
  // per endpoint: 0 ctrl out, 1 ctrl in, 2..15 endpoints 1..14
  typedef struct packed {
    logic [NUM_EP-1:0] ack_done;
    logic [NUM_EP-1:0] iso_done;
    logic [NUM_EP-1:0] is_iso;
  } ep_evt_t;
endpackage

// File: src/usb_irq_top.sv
// interrupt flags, masking and interrupt pin of the usb peripheral
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module usb_irq_top
  import usb_irq_pkg::*;
#(
  parameter int FRAME_LEN = usb_irq_pkg::FRAME_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // register bus slave
  input wire logic [usb_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [usb_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // events from the serial engine and dma
  input wire usb_irq_pkg::bus_evt_t bus_evt,
  input wire usb_irq_pkg::ep_evt_t ep_evt,
  // interrupt pin and suspend state
  output logic irq_pin,
  output logic suspend_state
);
  import usb_irq_pkg::*;

  initial begin
    if (FRAME_LEN < 2) $error("FRAME_LEN too short");
  end

  // merge written bytes into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction

  // endpoint status window hit test
  function automatic logic ep_hit(input logic [ADDR_W-1:0] a);
    return (a >= OFS_EP_BASE) && (a < ADDR_W'(OFS_EP_BASE + 4 * NUM_EP)) && (a[1:0] == 2'b00);
  endfunction

  // endpoint index inside the window
  function automatic logic [3:0] ep_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - OFS_EP_BASE;
    return off[5:2];
  endfunction

  // bus slave state
  logic aw_have_r, aw_have_nxt; // write address held
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic w_have_r, w_have_nxt; // write data held
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // software controls
  logic [FLAG_W-1:0] enable_r, enable_nxt; // per-source enables
  logic gie_r, gie_nxt; // global enable
  logic pol_r, pol_nxt; // 1 = active high
  logic sigmode_r, sigmode_nxt; // 1 = pulse mode
  // latched flags; sleep bit slot is never stored
  logic [FLAG_W-1:0] flags_r, flags_nxt;
  logic sleep_prev_r, sleep_prev_nxt; // for suspend edge
  logic irq_r, irq_nxt; // registered pin

  // helper nets
  logic pseudo_tick; // from frame watchdog
  logic wd_suspend; // three frames lost
  logic sleep_now; // live bus sleep state
  logic pending; // any enabled flag, globally enabled
  logic pulse; // pulse-mode output
  logic [FLAG_W-1:0] set_vec; // events this cycle
  logic [FLAG_W-1:0] clr_vec; // read-side clears this cycle
  logic [FLAG_W-1:0] status_word; // as seen by a read
  logic [NUM_EP-1:0] ep_done; // qualified endpoint completions
  logic wr_fire, rd_fire;

  frame_watchdog #(
    .FRAME_LEN(FRAME_LEN),
    .MISS_LIMIT(MISSED_SOF_LIMIT)
  ) u_wd (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sof(bus_evt.sof),
    .tick(pseudo_tick),
    .suspend(wd_suspend)
  );

  irq_pulse_gen #(
    .PULSE_LEN(PULSE_CYCLES)
  ) u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .trig(pending),
    .pulse(pulse)
  );

  // event qualification and status view
  always_comb begin
    // the engine reports ack_done only once the handshake is done,
    // so setup/out flags of non-iso endpoints never rise before the data is acknowledged
    ep_done = (ep_evt.ack_done & ~ep_evt.is_iso)
            | (ep_evt.iso_done & ep_evt.is_iso);
    sleep_now = bus_evt.bus_suspended | wd_suspend;
    set_vec = '0;
    set_vec[BIT_BUS_RESET] = bus_evt.bus_reset;
    set_vec[BIT_RESUME] = bus_evt.resume;
    set_vec[BIT_SUSP_CHG] = sleep_now & ~sleep_prev_r;
    set_vec[BIT_XFER_END] = bus_evt.dma_count_zero;
    set_vec[BIT_SOF] = bus_evt.sof;
    set_vec[BIT_PSEUDO] = pseudo_tick;
    set_vec[BIT_SPKT_END] = bus_evt.short_packet_end;
    set_vec[FLAG_W-1:BIT_EP_BASE] = ep_done;
    status_word = flags_r;
    status_word[BIT_SLEEP] = sleep_now;
    // bus sleep bit is a level, never an interrupt source
    pending = gie_r && ((flags_r & enable_r) != '0);
  end

  // bus handshake outputs; all drop while ce is low, since a frozen slave
  // would otherwise lose a beat the master believes was taken
  assign s_axi_awready = ce && !aw_have_r && !bvalid_r;
  assign s_axi_wready = ce && !w_have_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // bus slave, register writes and read side effects
  always_comb begin
    logic [31:0] tmp;
    tmp = '0;
    aw_have_nxt = aw_have_r;
    awaddr_nxt = awaddr_r;
    w_have_nxt = w_have_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    enable_nxt = enable_r;
    gie_nxt = gie_r;
    pol_nxt = pol_r;
    sigmode_nxt = sigmode_r;
    clr_vec = '0;
    // address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
    // write once both halves are held
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (awaddr_r == OFS_ENABLE) begin
        tmp = merge({{(32 - FLAG_W){1'b0}}, enable_r}, wdata_r, wstrb_r);
        enable_nxt = tmp[FLAG_W-1:0];
      end else if (awaddr_r == OFS_MODE) begin
        tmp = merge({31'h0, gie_r}, wdata_r, wstrb_r);
        gie_nxt = tmp[MODE_GIE_BIT];
      end else if (awaddr_r == OFS_HWCFG) begin
        tmp = merge({30'h0, sigmode_r, pol_r}, wdata_r, wstrb_r);
        pol_nxt = tmp[CFG_POL_BIT];
        sigmode_nxt = tmp[CFG_MODE_BIT];
      end else if (awaddr_r == OFS_STATUS || ep_hit(awaddr_r)) begin
        bresp_nxt = RESP_OKAY; // read-only, write ignored
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    // whole word returned in one beat, so a read is always complete
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = '0;
      if (s_axi_araddr == OFS_STATUS) begin
        rdata_nxt = {{(32 - FLAG_W){1'b0}}, status_word};
        clr_vec = READ_CLR_MASK;
      end else if (s_axi_araddr == OFS_ENABLE) begin
        rdata_nxt = {{(32 - FLAG_W){1'b0}}, enable_r};
      end else if (s_axi_araddr == OFS_MODE) begin
        rdata_nxt[MODE_GIE_BIT] = gie_r;
      end else if (s_axi_araddr == OFS_HWCFG) begin
        rdata_nxt[CFG_POL_BIT] = pol_r;
        rdata_nxt[CFG_MODE_BIT] = sigmode_r;
      end else if (ep_hit(s_axi_araddr)) begin
        rdata_nxt[0] = flags_r[BIT_EP_BASE + ep_idx(s_axi_araddr)];
        clr_vec[BIT_EP_BASE + ep_idx(s_axi_araddr)] = 1'b1;
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  // flags and pin: a new event beats a same-cycle clear
  always_comb begin
    flags_nxt = (flags_r & ~clr_vec) | set_vec;
    flags_nxt[BIT_SLEEP] = 1'b0;
    sleep_prev_nxt = sleep_now;
    // pick signalling, then apply polarity
    if (sigmode_r) begin
      irq_nxt = pol_r ? pulse : ~pulse;
    end else begin
      irq_nxt = pol_r ? pending : ~pending;
    end
  end

  // register stage for everything above
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awaddr_r <= '0;
      w_have_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      enable_r <= ENABLE_RST;
      gie_r <= GIE_RST;
      pol_r <= POL_RST;
      sigmode_r <= SIGMODE_RST;
      flags_r <= '0;
      sleep_prev_r <= 1'b0;
      irq_r <= 1'b1; // inactive for active-low default
    end else if (ce) begin
      aw_have_r <= aw_have_nxt;
      awaddr_r <= awaddr_nxt;
      w_have_r <= w_have_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      enable_r <= enable_nxt;
      gie_r <= gie_nxt;
      pol_r <= pol_nxt;
      sigmode_r <= sigmode_nxt;
      flags_r <= flags_nxt;
      sleep_prev_r <= sleep_prev_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign s_axi_bvalid = ce && bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = ce && rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq_pin = irq_r;
  assign suspend_state = sleep_prev_r;
endmodule // usb_irq_top

// File: test/tb_top.sv
// bench for the usb interrupt block
`timescale 1ns/1ps
module tb_top;
  import usb_irq_pkg::*;
  localparam int FL = 300; // shortened frame
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1; // dropped once to freeze the block
  logic susp = 1'b0; // live bus suspend level
  logic [15:0] iso = '0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic irq_pin, suspend_state;
  bus_evt_t bus_evt;
  ep_evt_t ep_evt;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int bits[5] = '{0, 1, 6, 3, 4}; // flag bit of each bus event kind

  usb_irq_top #(.FRAME_LEN(FL)) usb_irq_top_i (.*);
  usb_evt_model usb_evt_model_i (.aclk, .susp, .iso, .bus_evt, .ep_evt);

  initial forever #5 aclk = ~aclk;

  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // response ready is late on purpose so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask

  // restart the frame count and clear bus flags
  task automatic sync();
    usb_evt_model_i.fire(4, 0);
    rd(OFS_STATUS);
  endtask

  task automatic pulse(input int e);
    int n;
    n = 0;
    usb_evt_model_i.fire(0, 0);
    repeat (40) begin
      @(posedge aclk);
      if (irq_pin === 1'b1) n++;
    end
    chk(n, e);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFS_ENABLE, 0);
    rc(OFS_MODE, 0);
    rc(OFS_HWCFG, 0);
    chk(irq_pin, 1);
    rc(8'h20, 0);
    chk(r, RESP_SLVERR);
    wr(8'h20, 1);
    chk(r, RESP_SLVERR);
    wr(OFS_STATUS, 32'hffffffff);
    chk(r, RESP_OKAY);
    $display("test reset done");
    wr(OFS_ENABLE, 32'h00ffff7f);
    rc(OFS_ENABLE, 32'h00ffff7f);
    for (int k = 0; k < 5; k++) begin
      sync();
      usb_evt_model_i.fire(k, 0);
      rc(OFS_STATUS, 32'h1 << bits[k]);
      rc(OFS_STATUS, 0);
    end
    $display("test bus flags done");
    sync();
    usb_evt_model_i.fire(1, 0);
    repeat (3) @(posedge aclk);
    chk(irq_pin, 1);
    wr(OFS_MODE, 1);
    repeat (3) @(posedge aclk);
    chk(irq_pin, 0);
    wr(OFS_ENABLE, 1);
    repeat (3) @(posedge aclk);
    chk(irq_pin, 1);
    wr(OFS_ENABLE, 2);
    rd(OFS_STATUS);
    repeat (3) @(posedge aclk);
    chk(irq_pin, 1);
    $display("test level done");
    iso <= 16'hc000;
    for (int i = 0; i < 16; i++) begin
      sync();
      usb_evt_model_i.fire(iso[i] ? 6 : 5, i);
      rc(OFS_STATUS, 32'h100 << i);
      rc(OFS_STATUS, 32'h100 << i);
      rc(OFS_EP_BASE + 8'(4 * i), 1);
      rc(OFS_STATUS, 0);
    end
    usb_evt_model_i.fire(6, 2);
    usb_evt_model_i.fire(5, 15);
    rc(OFS_STATUS, 0);
    $display("test endpoints done");
    wr(OFS_ENABLE, 1);
    wr(OFS_HWCFG, 3);
    rc(OFS_HWCFG, 3);
    sync();
    pulse(17);
    pulse(0);
    rd(OFS_STATUS);
    pulse(17);
    wr(OFS_HWCFG, 1);
    repeat (3) @(posedge aclk);
    chk(irq_pin, 1);
    $display("test pulse done");
    wr(OFS_ENABLE, 32'h30);
    sync();
    repeat (FL + 10) @(posedge aclk);
    chk(irq_pin, 1);
    rc(OFS_STATUS, 32'h20);
    repeat (2 * FL) @(posedge aclk);
    chk(suspend_state, 1);
    rc(OFS_STATUS, 32'ha4);
    rc(OFS_STATUS, 32'h80);
    usb_evt_model_i.fire(4, 0);
    susp <= 1'b1;
    @(posedge aclk);
    rc(OFS_STATUS, 32'h94);
    susp <= 1'b0;
    @(posedge aclk);
    rc(OFS_STATUS, 0);
    $display("test frames done");
    ce <= 1'b0;
    usb_evt_model_i.fire(1, 0);
    chk(s_axi_arready, 0);
    ce <= 1'b1;
    rc(OFS_STATUS, 0);
    $display("test enable done");
    summarize();
  end
endmodule // tb_top

bind usb_irq_top usb_irq_chk usb_irq_chk_i (.*);

// File: test/usb_evt_model.sv
// stand-in for the serial engine and dma event lines
`timescale 1ns/1ps
module usb_evt_model
  import usb_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic susp,
  input wire logic [15:0] iso,
  output usb_irq_pkg::bus_evt_t bus_evt,
  output usb_irq_pkg::ep_evt_t ep_evt
);
  logic [4:0] bus_p = '0; // reset, resume, short end, dma zero, sof
  logic [15:0] ack_p = '0; // acked handshake per endpoint
  logic [15:0] iso_p = '0; // packet done per iso endpoint
  // live bus level and endpoint kind pass straight through
  assign bus_evt = {bus_p, susp};
  assign ep_evt = {ack_p, iso_p, iso};
  // one-cycle pulse, then a settle cycle so a read sees the flag
  task automatic fire(input int k, input int ep);
    @(posedge aclk);
    if (k < 5) bus_p[4-k] <= 1'b1;
    else if (k == 5) ack_p[ep] <= 1'b1;
    else iso_p[ep] <= 1'b1;
    @(posedge aclk);
    bus_p <= '0;
    ack_p <= '0;
    iso_p <= '0;
    @(posedge aclk);
  endtask
endmodule // usb_evt_model

// File: test/usb_irq_chk.sv
// port assertions for the usb interrupt block
`timescale 1ns/1ps
module usb_irq_chk
  import usb_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [usb_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire usb_irq_pkg::bus_evt_t bus_evt,
  input wire logic irq_pin,
  input wire logic suspend_state
);
  // one domain; a low clock enable freezes state, so checks pause too
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  // both write halves taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // status read taken while the bus has sat suspended
  sequence sleep_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STATUS
      && bus_evt.bus_suspended && $past(bus_evt.bus_suspended);
  endsequence
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  chk_sleep_bit: assert property (sleep_read |=> s_axi_rdata[BIT_SLEEP])
    else $error("sleep bit not live");
  chk_suspend_follow: assert property (bus_evt.bus_suspended [*2] |-> suspend_state)
    else $error("suspend state lags bus");
  chk_reset_pin: assert property ($rose(aresetn) |-> irq_pin && !suspend_state)
    else $error("pin not idle after reset");
endmodule // usb_irq_chk
